// ---- rtl/sdram_core.sv ----
// Command decoder, bank state, burst engine and APB settings of the memory
//
// Overview of operation
// - Sample all pins on rising clock edge
// - Four banks of 4096 rows, 256x32
// - Activate latches bank and row together
// - Read/write address sets burst start column
// - Burst length 1,2,4,8 or page, ordered
// - Burst terminate cuts an ongoing burst
// - Auto precharge closes row after burst
// - New column accepted every clock cycle
// - Burst columns generated internally
// - Precharge one bank while another bursts
// - Auto refresh and power-down supported
// - Chip select high masks new commands
// - Address bit ten: auto precharge/all banks
// - Byte masks block writes, hide reads
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module sdram_core
	import sdram_pkg::*;
(
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [PADDR_W-1:0] paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Memory command pins
	input  wire logic               cke,
	input  wire cmd_pins_t          cmd_pins,
	input  wire logic [BANK_W-1:0]  bank_select_inputs,
	input  wire logic [ROW_W-1:0]   multiplexed_address_inputs,
	input  wire logic [LANES-1:0]   byte_lane_masks,
	// Data pins
	input  wire logic [DATA_W-1:0]  dq_in,
	output logic      [DATA_W-1:0]  dq_out,
	output logic      [LANES-1:0]   dq_oe
);

	mode_cfg_t         cfg_ff;
	pwr_state_t        pwr_ff;
	logic [15:0]       refresh_cnt_ff;
	logic              bank_open_ff [BANKS];
	logic [ROW_W-1:0]  row_ff [BANKS];
	logic [BANKS-1:0]  open_vec;
	logic              burst_active_ff;
	logic              burst_wr_ff;
	logic              burst_ap_ff;
	logic              burst_intlv_ff;
	logic [BANK_W-1:0] burst_bank_ff;
	logic [COL_W-1:0]  start_col_ff;
	logic [8:0]        idx_ff;
	logic [8:0]        len_ff;
	logic [DATA_W-1:0] rd_d1_ff;
	logic [DATA_W-1:0] rd_d2_ff;
	logic [2:0]        rd_v_ff;
	logic [LANES-1:0]  dqm_d1_ff;
	logic [DATA_W-1:0] dq_out_ff;
	logic [LANES-1:0]  dq_oe_ff;
	logic [31:0]       prdata_ff;
	logic              pready_ff;
	logic              pslverr_ff;

	logic              cmd_valid;
	logic [2:0]        cmd_code;
	logic              is_act;
	logic              is_rd;
	logic              is_wr;
	logic              is_rdwr;
	logic              is_pre;
	logic              is_ref;
	logic              is_bst;
	logic              is_lmr;
	logic [8:0]        cmd_len;
	logic [COL_W-1:0]  cur_col;
	logic              burst_last;
	logic              ap_close_now;
	logic [BANK_W-1:0] ap_bank;
	logic [MEM_AW-1:0] mem_addr;
	logic              mem_re;
	logic              mem_we;
	logic [LANES-1:0]  mem_be;
	logic [DATA_W-1:0] mem_rdata;
	logic              apb_access;
	logic              apb_done;
	logic              hit_config;
	logic              hit_status;
	logic [31:0]       status_word;

	function automatic logic [8:0] len_of(input logic [2:0] bl);
		case (bl)
			BL_1:    len_of = LEN_1;
			BL_2:    len_of = LEN_2;
			BL_4:    len_of = LEN_4;
			BL_8:    len_of = LEN_8;
			BL_PAGE: len_of = LEN_PAGE;
			default: len_of = LEN_1;
		endcase
	endfunction : len_of

	// Column of beat idx, wrapping inside the burst-sized block
	function automatic logic [COL_W-1:0] col_of(
		input logic [COL_W-1:0] start,
		input logic [8:0]       idx,
		input logic [8:0]       len,
		input logic             intlv
	);
		logic [COL_W-1:0] m;
		logic [COL_W-1:0] i;
		logic [COL_W-1:0] step;
		m = COL_W'(len - LEN_1);
		i = idx[COL_W-1:0];
		step = intlv ? (start ^ i) : COL_W'(start + i);
		col_of = (start & ~m) | (step & m);
	endfunction : col_of

	// Decode on the sampled pins; masked by chip select and power-down
	assign cmd_valid = ~cmd_pins.cs_n & cke & (pwr_ff == PWR_RUN);
	assign cmd_code  = {cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n};
	assign is_act  = cmd_valid & (cmd_code == CMD_ACTIVE);
	assign is_rd   = cmd_valid & (cmd_code == CMD_READ);
	assign is_wr   = cmd_valid & (cmd_code == CMD_WRITE);
	assign is_pre  = cmd_valid & (cmd_code == CMD_PRECHARGE);
	assign is_ref  = cmd_valid & (cmd_code == CMD_REFRESH);
	assign is_bst  = cmd_valid & (cmd_code == CMD_TERMINATE);
	assign is_lmr  = cmd_valid & (cmd_code == CMD_LOAD_MODE);
	assign is_rdwr = is_rd | is_wr;

	assign cmd_len    = len_of(cfg_ff.burst_length_setting);
	assign cur_col    = col_of(start_col_ff, idx_ff, len_ff,
		burst_intlv_ff);
	assign burst_last = burst_active_ff & (idx_ff == 9'(len_ff - LEN_1));

	// A self-timed close fires when the burst ends or is cut short
	assign ap_close_now = (burst_active_ff & burst_ap_ff &
		(burst_last | is_rdwr | is_bst)) |
		(is_rdwr & multiplexed_address_inputs[AP_BIT] &
		(cmd_len == LEN_1));
	assign ap_bank = (burst_active_ff & burst_ap_ff) ? burst_bank_ff :
		bank_select_inputs;

	// Per-bank row state
	for (genvar b = 0; b < BANKS; b++) begin : g_bank
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				bank_open_ff[b] <= 1'b0;
			end else if (is_act && bank_select_inputs == BANK_W'(b)) begin
				bank_open_ff[b] <= 1'b1;
			end else if (is_pre && (multiplexed_address_inputs[AP_BIT] ||
				bank_select_inputs == BANK_W'(b))) begin
				bank_open_ff[b] <= 1'b0;
			end else if (ap_close_now && ap_bank == BANK_W'(b)) begin
				bank_open_ff[b] <= 1'b0;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				row_ff[b] <= '0;
			end else if (is_act && bank_select_inputs == BANK_W'(b)) begin
				row_ff[b] <= multiplexed_address_inputs;
			end
		end

		assign open_vec[b] = bank_open_ff[b];
	end

	// Burst engine; a new column command always takes over at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			burst_active_ff <= 1'b0;
			burst_wr_ff     <= 1'b0;
			burst_ap_ff     <= 1'b0;
			burst_intlv_ff  <= 1'b0;
			burst_bank_ff   <= '0;
			start_col_ff    <= '0;
			idx_ff          <= '0;
			len_ff          <= LEN_1;
		end else if (is_rdwr) begin
			burst_active_ff <= cmd_len != LEN_1;
			burst_wr_ff     <= is_wr;
			burst_ap_ff     <= multiplexed_address_inputs[AP_BIT];
			burst_intlv_ff  <= cfg_ff.interleave;
			burst_bank_ff   <= bank_select_inputs;
			start_col_ff    <= multiplexed_address_inputs[COL_W-1:0];
			idx_ff          <= LEN_1;
			len_ff          <= cmd_len;
		end else if (is_bst || burst_last) begin
			burst_active_ff <= 1'b0;
		end else if (burst_active_ff) begin
			idx_ff <= 9'(idx_ff + LEN_1);
		end
	end

	// First beat goes straight from the pins so no cycle is lost
	assign mem_addr = is_rdwr ?
		{bank_select_inputs, row_ff[bank_select_inputs],
		multiplexed_address_inputs[COL_W-1:0]} :
		{burst_bank_ff, row_ff[burst_bank_ff], cur_col};
	assign mem_we = is_wr |
		(burst_active_ff & burst_wr_ff & ~is_rdwr & ~is_bst);
	assign mem_re = is_rd |
		(burst_active_ff & ~burst_wr_ff & ~is_rdwr & ~is_bst);
	assign mem_be = ~byte_lane_masks;

	sdram_array #(
		.AW (MEM_AW),
		.DW (DATA_W),
		.BW (LANES)
	) u_array (
		.pclk  (pclk),
		.addr  (mem_addr),
		.re    (mem_re),
		.we    (mem_we),
		.be    (mem_be),
		.wdata (dq_in),
		.rdata (mem_rdata)
	);

	// Read latency pipeline; the data word and its valid flag are shifted, not the address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_v_ff  <= '0;
			rd_d1_ff <= '0;
			rd_d2_ff <= '0;
		end else begin
			rd_v_ff  <= {rd_v_ff[1:0], mem_re};
			rd_d1_ff <= mem_rdata;
			rd_d2_ff <= rd_d1_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dqm_d1_ff <= '0;
		end else begin
			dqm_d1_ff <= byte_lane_masks;
		end
	end

	// Settings above the deepest tap fall back to the longest latency
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dq_out_ff <= '0;
			dq_oe_ff  <= '0;
		end else begin
			case (cfg_ff.read_latency_setting)
				CL_1: begin
					dq_out_ff <= mem_rdata;
					dq_oe_ff  <= {LANES{rd_v_ff[0]}} & ~dqm_d1_ff;
				end
				CL_2: begin
					dq_out_ff <= rd_d1_ff;
					dq_oe_ff  <= {LANES{rd_v_ff[1]}} & ~dqm_d1_ff;
				end
				default: begin
					dq_out_ff <= rd_d2_ff;
					dq_oe_ff  <= {LANES{rd_v_ff[2]}} & ~dqm_d1_ff;
				end
			endcase
		end
	end

	// Power-down waits for a running burst to finish
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_ff <= PWR_RUN;
		end else begin
			case (pwr_ff)
				PWR_RUN: if (!cke && !burst_active_ff) begin
					pwr_ff <= PWR_DOWN;
				end
				PWR_DOWN: if (cke) begin
					pwr_ff <= PWR_RUN;
				end
				default: pwr_ff <= PWR_RUN;
			endcase
		end
	end

	// Refresh only counts with every bank closed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refresh_cnt_ff <= '0;
		end else if (is_ref && open_vec == '0) begin
			refresh_cnt_ff <= 16'(refresh_cnt_ff + 16'h0001);
		end
	end

	// APB slave: one wait state, then the answer
	assign apb_access = psel & penable;
	assign apb_done   = apb_access & pready_ff;
	assign hit_config = paddr == ADDR_CONFIG;
	assign hit_status = paddr == ADDR_STATUS;
	assign status_word = {refresh_cnt_ff, 10'h000, pwr_ff == PWR_DOWN,
		burst_active_ff, open_vec};

	// A software write wins over a mode load in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= CFG_RESET;
		end else if (apb_done && pwrite && hit_config) begin
			cfg_ff <= pwdata[LOAD_MODE_W-1:0];
		end else if (is_lmr) begin
			cfg_ff <= multiplexed_address_inputs[LOAD_MODE_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= '0;
		end else begin
			pready_ff  <= apb_access & ~pready_ff;
			pslverr_ff <= apb_access & ~pready_ff & ~hit_config & ~hit_status;
			if (apb_access && !pready_ff && !pwrite && hit_config) begin
				prdata_ff <= {25'h0000000, cfg_ff};
			end else if (apb_access && !pready_ff && !pwrite && hit_status) begin
				prdata_ff <= status_word;
			end else begin
				prdata_ff <= '0;
			end
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = pready_ff;
	assign pslverr = pslverr_ff;
	assign dq_out  = dq_out_ff;
	assign dq_oe   = dq_oe_ff;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_act_opens_row: assert property (
		is_act && !ap_close_now |=> open_vec[$past(bank_select_inputs)] &&
		row_ff[$past(bank_select_inputs)] == $past(multiplexed_address_inputs))
		else $error("activate did not open the row");

	a_burst_eight: assert property (
		(is_rdwr && cmd_len == LEN_8) ##1 (!is_rdwr && !is_bst)[*7]
		|=> !burst_active_ff)
		else $error("eight-beat burst has wrong length");

	a_burst_runs: assert property (
		burst_active_ff && !burst_last && !is_rdwr && !is_bst
		|=> burst_active_ff)
		else $error("burst stopped early");

	a_term_stops: assert property (
		burst_active_ff && is_bst && !is_rdwr
		|-> (!mem_re && !mem_we) ##1 !burst_active_ff)
		else $error("terminate did not stop the burst");

	a_auto_close: assert property (
		burst_last && burst_ap_ff && !is_act && !is_rdwr
		|=> !open_vec[$past(burst_bank_ff)])
		else $error("auto precharge did not close the row");

	a_col_step: assert property (
		burst_active_ff && !burst_intlv_ff && !burst_last && !is_rdwr &&
		!is_bst && (cur_col & COL_W'(len_ff - LEN_1)) != COL_W'(len_ff - LEN_1)
		|=> cur_col == COL_W'($past(cur_col) + 8'h01))
		else $error("burst column did not advance");

	a_start_col: assert property (
		is_rdwr |-> mem_addr[COL_W-1:0] == multiplexed_address_inputs[COL_W-1:0]
		&& (mem_re || mem_we))
		else $error("start column not used at once");

	a_pre_all: assert property (
		is_pre && multiplexed_address_inputs[AP_BIT] |=> open_vec == '0)
		else $error("precharge all left a bank open");

	a_pre_hidden: assert property (
		is_pre && !multiplexed_address_inputs[AP_BIT] && burst_active_ff &&
		!burst_last && bank_select_inputs != burst_bank_ff
		|=> burst_active_ff && !open_vec[$past(bank_select_inputs)])
		else $error("precharge disturbed the other bank");

	a_mask_hides: assert property (
		byte_lane_masks[0] |=> ##1 !dq_oe[0])
		else $error("masked read lane was driven");

	a_refresh_count: assert property (
		is_ref && open_vec == '0 |=> refresh_cnt_ff == 16'($past(refresh_cnt_ff)
		+ 16'h0001))
		else $error("refresh not counted");

	c_page_burst: cover property (
		(is_rdwr && cmd_len == LEN_PAGE) ##[1:300] burst_last);
	c_term_burst: cover property (burst_active_ff && is_bst);
	c_auto_close: cover property (burst_last && burst_ap_ff);
	c_power_down: cover property (pwr_ff == PWR_DOWN);

endmodule : sdram_core
`default_nettype wire

// ---- common/sdram_pkg.sv ----
// Shared constants, carriers and types for the quad-bank memory core
package sdram_pkg;

	// Array geometry
	localparam int BANKS    = 4;
	localparam int BANK_W   = 2;
	localparam int ROW_W    = 12;
	localparam int COL_W    = 8;
	localparam int DATA_W   = 32;
	localparam int LANES    = 4;
	localparam int MEM_AW   = BANK_W + ROW_W + COL_W;

	// Address bit that asks for auto precharge or all-bank precharge
	localparam int AP_BIT   = 10;

	// Command codes on {row strobe, column strobe, write enable}
	localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
	localparam logic [2:0] CMD_REFRESH   = 3'h1;
	localparam logic [2:0] CMD_PRECHARGE = 3'h2;
	localparam logic [2:0] CMD_ACTIVE    = 3'h3;
	localparam logic [2:0] CMD_WRITE     = 3'h4;
	localparam logic [2:0] CMD_READ      = 3'h5;
	localparam logic [2:0] CMD_TERMINATE = 3'h6;

	// Burst length setting codes
	localparam logic [2:0] BL_1    = 3'h0;
	localparam logic [2:0] BL_2    = 3'h1;
	localparam logic [2:0] BL_4    = 3'h2;
	localparam logic [2:0] BL_8    = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;

	// Burst lengths in locations
	localparam logic [8:0] LEN_1    = 9'h001;
	localparam logic [8:0] LEN_2    = 9'h002;
	localparam logic [8:0] LEN_4    = 9'h004;
	localparam logic [8:0] LEN_8    = 9'h008;
	localparam logic [8:0] LEN_PAGE = 9'h100;

	// Read latency settings
	localparam logic [2:0] CL_1 = 3'h1;
	localparam logic [2:0] CL_2 = 3'h2;

	// APB map
	localparam int         PADDR_W     = 12;
	localparam logic [11:0] ADDR_CONFIG = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam int         LOAD_MODE_W = 7;

	// Pin group of the command decoder
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} cmd_pins_t;

	// Mode settings, laid out as address bits 6..0 of a mode load
	typedef struct packed {
		logic [2:0] read_latency_setting;
		logic       interleave;
		logic [2:0] burst_length_setting;
	} mode_cfg_t;

	localparam mode_cfg_t CFG_RESET = 7'h20;

	typedef enum logic {PWR_RUN, PWR_DOWN} pwr_state_t;

endpackage : sdram_pkg

// ---- rtl/sdram_array.sv ----
// Storage array with per-lane write enables and registered read data
`timescale 1ns/1ps
`default_nettype none
module sdram_array
	import sdram_pkg::*;
#(
	parameter int AW = MEM_AW,
	parameter int DW = DATA_W,
	parameter int BW = LANES
) (
	// Clock
	input  wire logic          pclk,
	// Access port
	input  wire logic [AW-1:0] addr,
	input  wire logic          re,
	input  wire logic          we,
	input  wire logic [BW-1:0] be,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata
);

	localparam int LW = DW / BW;

	logic [DW-1:0] mem [2**AW];

	// Lane writes; storage itself has no reset, like a real array
	for (genvar l = 0; l < BW; l++) begin : g_lane
		always_ff @(posedge pclk) begin
			if (we && be[l]) begin
				mem[addr][l*LW +: LW] <= wdata[l*LW +: LW];
			end
		end
	end

	always_ff @(posedge pclk) begin
		if (re) begin
			rdata <= mem[addr];
		end
	end

endmodule : sdram_array
`default_nettype wire

// ---- bench/mem_ctl_model.sv ----
// Behavioural memory controller that drives the command side of the core
`timescale 1ns/1ps
`default_nettype none
module mem_ctl_model
	import sdram_pkg::*;
(
	// Clock
	input  wire logic               pclk,
	// Command side
	output var  logic               cke,
	output var  cmd_pins_t          cmd_pins,
	output var  logic [BANK_W-1:0]  bank_select_inputs,
	output var  logic [ROW_W-1:0]   multiplexed_address_inputs,
	output var  logic [LANES-1:0]   byte_lane_masks,
	output var  logic [DATA_W-1:0]  dq_in
);
	initial begin
		cke = 1'b1;
		cmd_pins = 4'hF;
		bank_select_inputs = 2'h0;
		multiplexed_address_inputs = 12'h000;
		byte_lane_masks = 4'h0;
		dq_in = 32'h0000_0000;
	end

	// Pins move just after an edge, so the core samples them settled
	task automatic step(input logic cs_n, input logic [2:0] cmd,
		input logic [BANK_W-1:0] ba, input logic [ROW_W-1:0] a,
		input logic [LANES-1:0] m, input logic [DATA_W-1:0] d);
		@(posedge pclk);
		cmd_pins <= {cs_n, cmd};
		bank_select_inputs <= ba;
		multiplexed_address_inputs <= a;
		byte_lane_masks <= m;
		dq_in <= d;
	endtask : step

	// Data lines left alone show the inverse, never a stale word
	task automatic idle(input logic [LANES-1:0] m);
		step(1'b0, 3'h7, bank_select_inputs, multiplexed_address_inputs,
			m, ~dq_in);
	endtask : idle

	task automatic power(input logic v);
		@(posedge pclk);
		cke <= v;
	endtask : power
endmodule : mem_ctl_model
`default_nettype wire

// ---- bench/sdram_core_tb.sv ----
// Self-checking bench for the memory core and its settings registers
`timescale 1ns/1ps
`default_nettype none
module sdram_core_tb
	import sdram_pkg::*;
;
	logic               pclk = 1'b0;
	logic               presetn = 1'b0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite;
	logic [PADDR_W-1:0] paddr;
	logic [31:0]        pwdata;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic               cke;
	cmd_pins_t          cmd_pins;
	logic [BANK_W-1:0]  bank_select_inputs;
	logic [ROW_W-1:0]   multiplexed_address_inputs;
	logic [LANES-1:0]   byte_lane_masks;
	logic [DATA_W-1:0]  dq_in;
	logic [DATA_W-1:0]  dq_out;
	logic [LANES-1:0]   dq_oe;
	int                 fails = 0;
	int                 total_checks = 0;
	int                 cycles = 0;
	int                 len;
	logic [31:0]        mem [int];
	logic [31:0]        r;
	logic [31:0]        s0;
	logic [31:0]        d;
	logic [31:0]        d1;
	logic               e;
	logic               il;
	logic               ap;
	logic [1:0]         b;
	logic [11:0]        row;
	logic [7:0]         sc;
	logic [2:0]         cl;
	logic [6:0]         cfg;
	logic [2:0]         codes [5] = '{BL_1, BL_2, BL_4, BL_8, BL_PAGE};

	always #20 pclk = ~pclk;

	sdram_core sdram_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cke(cke),
		.cmd_pins(cmd_pins), .bank_select_inputs(bank_select_inputs),
		.multiplexed_address_inputs(multiplexed_address_inputs),
		.byte_lane_masks(byte_lane_masks), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe));

	mem_ctl_model mem_ctl_model_i (.pclk(pclk), .cke(cke),
		.cmd_pins(cmd_pins), .bank_select_inputs(bank_select_inputs),
		.multiplexed_address_inputs(multiplexed_address_inputs),
		.byte_lane_masks(byte_lane_masks), .dq_in(dq_in));

	task automatic summarize;
		if (fails == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	// Longest run is two page bursts per pass, far below this ceiling
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fails++;
			summarize();
		end
	end

	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		total_checks++;
		if (g !== x) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, x, g);
		end
	endtask : chk

	// Request held until the edge that sees pready high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends a wait that never sees pready
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic int blen(input logic [2:0] c);
		case (c)
			BL_2: return 2;
			BL_4: return 4;
			BL_8: return 8;
			BL_PAGE: return 256;
			default: return 1;
		endcase
	endfunction : blen

	function automatic logic [7:0] bcol(input logic [7:0] s, input int i,
		input int n, input logic lv);
		logic [7:0] m;
		m = 8'(n - 1);
		return lv ? ((s & ~m) | ((s ^ 8'(i)) & m))
			: ((s & ~m) | ((s + 8'(i)) & m));
	endfunction : bcol

	task automatic open_row(input logic [1:0] ba, input logic [11:0] ra);
		mem_ctl_model_i.step(1'b0, CMD_PRECHARGE, ba, 12'h400, 4'h0,
			$urandom);
		mem_ctl_model_i.step(1'b0, CMD_ACTIVE, ba, ra, 4'h0,
			$urandom);
	endtask : open_row

	initial begin
		void'($urandom(32'h2B789A37));
		// Idle bus fields carry noise; the core must ignore them
		pwrite <= 1'($urandom);
		paddr <= 12'($urandom);
		pwdata <= $urandom;
		repeat (16) @(posedge pclk);
		chk("reset lanes", 32'h0, 32'(dq_oe));
		chk("reset ready", 32'h0, 32'(pready));
		presetn <= 1'b1;
		apb(1'b0, ADDR_CONFIG, 0, r, e);
		chk("config reset", 32'h20, r);
		apb(1'b0, ADDR_STATUS, 0, r, e);
		chk("status reset", 32'h0, r);
		for (int it = 0; it < 10; it++) begin
			il = (it >= 5);
			ap = it[0];
			cl = 3'(1 + $urandom % 3);
			cfg = {cl, il, codes[it % 5]};
			len = blen(codes[it % 5]);
			b = 2'($urandom);
			row = 12'($urandom);
			sc = 8'($urandom);
			if (ap) begin
				mem_ctl_model_i.step(1'b0, CMD_LOAD_MODE, 0, {5'h0, cfg}, 0, 0);
				mem_ctl_model_i.idle(4'h0);
			end else
				apb(1'b1, ADDR_CONFIG, {25'h0, cfg}, r, e);
			apb(1'b0, ADDR_CONFIG, 0, r, e);
			chk("config", {25'h0, cfg}, r);
			open_row(b, row);
			for (int k = 0; k < len; k++) begin
				d = $urandom;
				mem[{b, row, bcol(sc, k, len, il)}] = d;
				mem_ctl_model_i.step(1'b0, k == 0 ? CMD_WRITE : 3'h7, b,
					{4'h0, sc}, 4'h0, d);
			end
			mem_ctl_model_i.step(1'b0, CMD_READ, b, {1'b0, ap, 2'b0, sc},
				4'h0, ~d);
			mem_ctl_model_i.idle(4'h0);
			repeat (cl) @(posedge pclk);
			for (int k = 0; k < len; k++) begin
				@(negedge pclk);
				chk("read word", mem[{b, row, bcol(sc, k, len, il)}], dq_out);
				chk("read lanes", 32'hF, 32'(dq_oe));
				@(posedge pclk);
			end
			apb(1'b0, ADDR_STATUS, 0, r, e);
			chk("open banks", ap ? 32'h0 : 32'(1 << b), {28'h0, r[3:0]});
		end
		apb(1'b1, ADDR_CONFIG, 32'h20, r, e);
		open_row(2'h1, 12'h005);
		d = $urandom;
		d1 = $urandom;
		mem_ctl_model_i.step(1'b0, CMD_WRITE, 2'h1, 12'h000, 4'h0, d);
		mem_ctl_model_i.step(1'b0, CMD_WRITE, 2'h1, 12'h000, 4'h3, d1);
		mem_ctl_model_i.step(1'b0, CMD_READ, 2'h1, 12'h000, 4'h0, ~d1);
		mem_ctl_model_i.idle(4'h5);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk("masked lanes", 32'hA, 32'(dq_oe));
		chk("masked word", {d1[31:24], 8'h0, d[15:8], 8'h0},
			dq_out & 32'hFF00FF00);
		apb(1'b1, ADDR_CONFIG, 32'h23, r, e);
		mem_ctl_model_i.step(1'b0, CMD_READ, 2'h1, 12'h000, 4'h0, 0);
		mem_ctl_model_i.step(1'b0, CMD_PRECHARGE, 2'h0, 12'h000, 4'h0,
			$urandom);
		mem_ctl_model_i.step(1'b0, CMD_TERMINATE, 2'h1, 12'h000, 4'h0, 0);
		mem_ctl_model_i.idle(4'h0);
		@(posedge pclk);
		@(negedge pclk);
		chk("beat before stop", 32'hF, 32'(dq_oe));
		@(posedge pclk);
		@(negedge pclk);
		chk("beat after stop", 32'h0, 32'(dq_oe));
		apb(1'b0, ADDR_STATUS, 0, r, e);
		chk("other bank open", 32'h2, {28'h0, r[3:0]});
		mem_ctl_model_i.step(1'b1, CMD_READ, 2'h1, 12'h000, 4'h0, 0);
		mem_ctl_model_i.idle(4'h0);
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		chk("deselected read", 32'h0, 32'(dq_oe));
		open_row(2'h1, 12'h005);
		mem_ctl_model_i.step(1'b0, CMD_PRECHARGE, 2'h0, 12'h400, 4'h0, 0);
		apb(1'b0, ADDR_STATUS, 0, s0, e);
		chk("all closed", 32'h0, {28'h0, s0[3:0]});
		mem_ctl_model_i.step(1'b0, CMD_REFRESH, 2'h0, 12'h000, 4'h0, 0);
		mem_ctl_model_i.idle(4'h0);
		apb(1'b0, ADDR_STATUS, 0, r, e);
		chk("refresh count", {16'h0, s0[31:16] + 16'h1}, {16'h0, r[31:16]});
		mem_ctl_model_i.power(1'b0);
		repeat (3) @(posedge pclk);
		apb(1'b0, ADDR_STATUS, 0, r, e);
		chk("power down", 32'h1, {31'h0, r[5]});
		mem_ctl_model_i.power(1'b1);
		repeat (3) @(posedge pclk);
		apb(1'b0, ADDR_STATUS, 0, r, e);
		chk("power up", 32'h0, {31'h0, r[5]});
		apb(1'b0, 12'h008, 0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
		summarize();
	end
endmodule : sdram_core_tb
`default_nettype wire
